// ==== src/xsd_pkg.sv ====
// package for the extended-set indexed decode block
// assumes a 12-bit data space and 16-bit instruction words
package xsd_pkg;
    localparam int          DADDR_W         = 12;
    localparam int          OFS7_W          = 7;
    localparam logic [11:0] ADR_PC_LOW      = 12'h0ff9;
    localparam logic [11:0] ADR_RST_LOW     = 12'h0ffd;
    localparam logic [11:0] ADR_RST_HIGH    = 12'h0ffe;
    localparam logic [11:0] ADR_RST_UPPER   = 12'h0fff;
    localparam logic [11:0] ADR_WREG        = 12'h0fe8;
    localparam logic [11:0] ACCESS_LIMIT    = 12'h005f;
    localparam logic [11:0] ACCESS_HI_BASE  = 12'h0f00;
    localparam logic [11:0] SFP_RESET       = 12'h0000;
    localparam logic [7:0]  WREG_RESET      = 8'h00;
    localparam logic [7:0]  ALL_ONES        = 8'hff;
    localparam logic [7:0]  IND_ZERO        = 8'h00;
    // nine bits: the move to a full address shares the top seven
    localparam logic [8:0]  OP_MOVE_IDX     = 9'h1d7;
    localparam logic [7:0]  OP_PUSH_LIT     = 8'hfa;
    localparam logic [9:0]  OP_SUBRET       = 10'h3a7;
    localparam logic [5:0]  OP_ADD_WORKING  = 6'h09;
    localparam logic [3:0]  OP_BIT_SET      = 4'h8;
    localparam logic [6:0]  OP_SET_ALL      = 7'h34;
    localparam logic [3:0]  OP_SECOND       = 4'hf;
    localparam int          STAT_N          = 4;
    localparam int          STAT_OV         = 3;
    localparam int          STAT_Z          = 2;
    localparam int          STAT_DC         = 1;
    localparam int          STAT_C          = 0;

    typedef enum logic [3:0] {
        XSD_FIRST  = 4'b0001,
        XSD_MOVE2  = 4'b0010,
        XSD_IDLE2  = 4'b0100,
        XSD_SKIP   = 4'b1000
    } xsd_state_e;

    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  data;
    } xsd_wr_s;
endpackage : xsd_pkg

// ==== src/xsd_addr_gen.sv ====
// operand address former: indexed or literal access-bank/banked
// assumes the pointer and bank selector are stable for the cycle
`timescale 1ns/10ps
module xsd_addr_gen
    import xsd_pkg::*;
#(
    parameter int OFS_W = 8
) (
    input  wire logic [11:0]      sfp,
    input  wire logic [3:0]       bank,
    input  wire logic [OFS_W-1:0] ofs,
    input  wire logic             indexed,
    input  wire logic             banked,
    output logic      [11:0]      addr
);
    // refuse widths that would not fit the low byte of the operand
    if (OFS_W < 1 || OFS_W > 8) begin : g_bad_ofs_w
        $error("xsd_addr_gen: offset width out of range");
    end

    logic [11:0] ofs_ext;
    assign ofs_ext = {{(12-OFS_W){1'b0}}, ofs};

    always_comb begin
        if (indexed) begin
            addr = sfp + ofs_ext;
        end else if (banked) begin
            addr = {bank, ofs_ext[7:0]};
        end else if (ofs_ext[7:0] <= ACCESS_LIMIT[7:0]) begin
            addr = ofs_ext;
        end else begin
            addr = ACCESS_HI_BASE | ofs_ext;
        end
    end
endmodule : xsd_addr_gen

// ==== src/xsd_decode.sv ====
// extended-set decode/execute: indexed move, push, subtract-return,
// indexed literal offset for add, bit set and set-all
// assumes one instruction word per cycle; q_phase one-hot Q1..Q4
`timescale 1ns/10ps
module xsd_decode
    import xsd_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [3:0]    q_phase,
    input  wire logic          instr_valid,
    input  wire logic [15:0]   instr,
    input  wire logic          ext_enable,
    input  wire logic [3:0]    bank_sel,
    input  wire logic [7:0]    rd_data,
    input  wire logic [20:0]   return_stack_top,
    output logic      [11:0]   rd_addr,
    output logic               rd_en,
    output xsd_wr_s            wr,
    output logic      [11:0]   stack_frame_pointer,
    output logic      [7:0]    working_reg,
    output logic      [4:0]    status_flags,
    output logic               pc_load,
    output logic      [20:0]   pc_value,
    output logic               busy
);
    xsd_state_e  state_r;
    logic [11:0] sfp_r;
    logic [7:0]  wreg_r;
    logic [4:0]  stat_r;
    logic [7:0]  hold_r;
    xsd_wr_s     wr_r;
    logic        pcl_r;
    logic [20:0] pcv_r;
    logic        en_r;

    wire q4 = q_phase[3];
    wire go = instr_valid && q4;

    // the enable is latched after reset release, then held
    logic en_caught_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_r        <= 1'b0;
            en_caught_r <= 1'b0;
        end else if (!en_caught_r) begin
            en_r        <= ext_enable;
            en_caught_r <= 1'b1;
        end
    end

    wire is_move   = en_r && instr[15:7] == OP_MOVE_IDX;
    wire is_push   = en_r && instr[15:8] == OP_PUSH_LIT;
    wire is_subret = en_r && instr[15:6] == OP_SUBRET;
    wire is_add    = instr[15:10] == OP_ADD_WORKING;
    wire is_bitset = instr[15:12] == OP_BIT_SET;
    wire is_setall = instr[15:9] == OP_SET_ALL;
    wire acc_a     = instr[8];
    // offset only at or below the access limit; otherwise literal mapping
    wire idx_mode  = en_r && !acc_a && instr[7:0] <= ACCESS_LIMIT[7:0];

    logic [11:0] file_addr;
    logic [11:0] move_addr;
    xsd_addr_gen #(.OFS_W(8)) u_file (
        .sfp     (sfp_r),
        .bank    (bank_sel),
        .ofs     (instr[7:0]),
        .indexed (idx_mode),
        .banked  (acc_a),
        .addr    (file_addr)
    );
    xsd_addr_gen #(.OFS_W(OFS7_W)) u_move (
        .sfp     (sfp_r),
        .bank    (bank_sel),
        .ofs     (instr[6:0]),
        .indexed (1'b1),
        .banked  (1'b0),
        .addr    (move_addr)
    );

    // indirect registers: three pointer groups of five each
    function automatic logic is_indirect(input logic [11:0] a);
        is_indirect = (a >= 12'h0feb && a <= 12'h0fef) ||
                      (a >= 12'h0fe3 && a <= 12'h0fe7) ||
                      (a >= 12'h0fdb && a <= 12'h0fdf);
    endfunction : is_indirect

    function automatic logic is_guarded(input logic [11:0] a);
        is_guarded = a == ADR_PC_LOW || a == ADR_RST_LOW || a == ADR_RST_HIGH ||
                     a == ADR_RST_UPPER;
    endfunction : is_guarded

    always_comb begin
        rd_en   = 1'b0;
        rd_addr = file_addr;
        if (go && state_r == XSD_FIRST) begin
            if (is_move) begin
                rd_en   = !is_indirect(move_addr);
                rd_addr = move_addr;
            end else if (is_add || is_bitset) begin
                rd_en   = 1'b1;
            end
        end
    end

    wire [7:0] rd_val = is_indirect(move_addr) ? IND_ZERO : rd_data;

    // add result and flags
    wire [8:0] sum9 = {1'b0, wreg_r} + {1'b0, rd_data};
    wire [4:0] lo5  = {1'b0, wreg_r[3:0]} + {1'b0, rd_data[3:0]};
    wire       ovf  = (wreg_r[7] == rd_data[7]) && (sum9[7] != wreg_r[7]);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= XSD_FIRST;
            hold_r  <= 8'h00;
        end else if (q4) begin
            case (state_r)
                XSD_FIRST: begin
                    if (go && is_move) begin
                        state_r <= XSD_MOVE2;
                        hold_r  <= rd_val;
                    end else if (go && is_subret) begin
                        state_r <= XSD_IDLE2;
                    end
                end
                XSD_MOVE2: begin
                    if (go) begin
                        state_r <= XSD_FIRST;
                    end
                end
                // the idle cycle needs no fetched word, so it ends on any Q4
                XSD_IDLE2: state_r <= XSD_FIRST;
                XSD_SKIP:  state_r <= XSD_FIRST;
                default:   state_r <= XSD_FIRST;
            endcase
        end
    end

    // data memory write requests are registered at the end of Q4 and presented in the following cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_r <= '0;
        end else begin
            wr_r.we <= 1'b0;
            if (go && state_r == XSD_MOVE2) begin
                wr_r.addr <= move_addr;
                wr_r.data <= hold_r;
                wr_r.we   <= instr[15:12] == OP_SECOND &&
                             !is_guarded(move_addr) &&
                             !is_indirect(move_addr);
            end else if (go && state_r == XSD_FIRST) begin
                if (is_push) begin
                    wr_r <= '{we: 1'b1, addr: sfp_r, data: instr[7:0]};
                end else if (is_add && instr[9]) begin
                    wr_r <= '{we: 1'b1, addr: file_addr, data: sum9[7:0]};
                end else if (is_bitset) begin
                    wr_r <= '{we: 1'b1, addr: file_addr,
                              data: rd_data | (8'h01 << instr[11:9])};
                end else if (is_setall) begin
                    wr_r <= '{we: 1'b1, addr: file_addr, data: ALL_ONES};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sfp_r <= SFP_RESET;
        end else if (go && state_r == XSD_FIRST) begin
            if (is_push) begin
                sfp_r <= sfp_r - 12'h001;
            end else if (is_subret) begin
                sfp_r <= sfp_r - {6'h00, instr[5:0]};
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wreg_r <= WREG_RESET;
            stat_r <= 5'h00;
        end else if (go && state_r == XSD_FIRST && is_add) begin
            if (!instr[9]) begin
                wreg_r <= sum9[7:0];
            end
            stat_r[STAT_N]  <= sum9[7];
            stat_r[STAT_OV] <= ovf;
            stat_r[STAT_Z]  <= sum9[7:0] == 8'h00;
            stat_r[STAT_DC] <= lo5[4];
            stat_r[STAT_C]  <= sum9[8];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pcl_r <= 1'b0;
            pcv_r <= 21'h00_0000;
        end else begin
            pcl_r <= go && state_r == XSD_FIRST && is_subret;
            if (go && state_r == XSD_FIRST && is_subret) begin
                pcv_r <= return_stack_top;
            end
        end
    end

    // a lone 1111 word other than an FAxx push falls through every decode above: no-op
    assign wr                  = wr_r;
    assign stack_frame_pointer = sfp_r;
    assign working_reg         = wreg_r;
    assign status_flags        = stat_r;
    assign pc_load             = pcl_r;
    assign pc_value            = pcv_r;
    assign busy                = state_r != XSD_FIRST;

    a_push_decr: assert property (@(posedge clk) disable iff (!nrst)
        go && state_r == XSD_FIRST && is_push |=> sfp_r == $past(sfp_r) - 12'h001
            && wr_r.we && wr_r.addr == $past(sfp_r)) else $error("push wrong");
    a_subret_idle: assert property (@(posedge clk) disable iff (!nrst)
        go && state_r == XSD_FIRST && is_subret |=> state_r == XSD_IDLE2 && pc_load)
        else $error("subtract-return not two cycles");
    a_move_guard: assert property (@(posedge clk) disable iff (!nrst)
        wr_r.we |-> !is_guarded(wr_r.addr)) else $error("guarded write");
    a_setall_ones: assert property (@(posedge clk) disable iff (!nrst)
        go && state_r == XSD_FIRST && is_setall && !is_move |=> wr_r.data == ALL_ONES)
        else $error("set-all data wrong");
    a_flags_hold: assert property (@(posedge clk) disable iff (!nrst)
        !(go && is_add) |=> $stable(stat_r)) else $error("flags moved");
    a_enable_off: assert property (@(posedge clk) disable iff (!nrst)
        !en_r |-> !busy || state_r == XSD_SKIP) else $error("ext active off");
    a_move_second: assert property (@(posedge clk) disable iff (!nrst)
        state_r == XSD_MOVE2 && go |=> state_r == XSD_FIRST) else $error("move stuck");
    a_idx_addr: assert property (@(posedge clk) disable iff (!nrst)
        idx_mode |-> file_addr == sfp_r + {4'h0, instr[7:0]}) else $error("index addr");
endmodule : xsd_decode

// ==== test/xsd_mem_model.sv ====
// data memory model on the far side of the decode block
// assumes one read or write request per cycle from the block
`timescale 1ns/10ps
module xsd_mem_model
    import xsd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [11:0] rd_addr,
    input  wire logic        rd_en,
    input  wire xsd_wr_s     wr,
    output logic      [7:0]  rd_data
);
    logic [7:0] mem    [0:4095];
    logic [7:0] last_r = 8'h00;

    // unselected read shows the inverse of the last byte, so stale data cannot match
    assign rd_data = rd_en ? mem[rd_addr] : ~last_r;

    always @(posedge clk) begin
        if (rd_en) begin
            last_r <= mem[rd_addr];
        end
        if (wr.we) begin
            mem[wr.addr] <= wr.data;
        end
    end
endmodule : xsd_mem_model

// ==== test/tb_xsd_decode.sv ====
// testbench for the extended-set decode block with a data memory model
// assumes one word per instruction cycle, presented Q1 through Q4
`timescale 1ns/10ps
module tb_xsd_decode
    import xsd_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  q_phase = 4'b0001;
    logic        instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic        ext_enable = 1'b1;
    logic [3:0]  bank_sel = 4'h5;
    logic [20:0] rs_top = 21'h1_2345;
    logic [7:0]  rd_data;
    logic [11:0] rd_addr;
    logic        rd_en;
    xsd_wr_s     wr;
    logic [11:0] sfp;
    logic [7:0]  working_reg;
    logic [4:0]  status_flags;
    logic        pc_load;
    logic [20:0] pc_value;
    logic        busy;
    int          miscompares = 0;
    int          comparisons = 0;
    logic [6:0]  bad_dst [5] = '{7'h19, 7'h1d, 7'h1e, 7'h1f, 7'h0b};

    always #20 clk = ~clk;
    always @(posedge clk) q_phase <= {q_phase[2:0], q_phase[3]};

    xsd_decode i_xsd_decode (
        .clk(clk), .nrst(nrst), .q_phase(q_phase), .instr_valid(instr_valid),
        .instr(instr), .ext_enable(ext_enable), .bank_sel(bank_sel),
        .rd_data(rd_data), .return_stack_top(rs_top), .rd_addr(rd_addr),
        .rd_en(rd_en), .wr(wr), .stack_frame_pointer(sfp),
        .working_reg(working_reg), .status_flags(status_flags),
        .pc_load(pc_load), .pc_value(pc_value), .busy(busy)
    );

    xsd_mem_model i_xsd_mem_model (
        .clk(clk), .rd_addr(rd_addr), .rd_en(rd_en), .wr(wr), .rd_data(rd_data)
    );

    task automatic results;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic chk_wr(input logic we, input logic [11:0] a, input logic [7:0] d);
        chk(21'(wr.we), 21'(we));
        if (we) begin
            chk(21'(wr.addr), 21'(a));
            chk(21'(wr.data), 21'(d));
        end
    endtask : chk_wr

    // wait for the edge that opens Q1; read before the phase update lands
    task automatic align;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (q_phase !== 4'b1000 && n < 9);
        if (q_phase !== 4'b1000) begin
            miscompares++;
            results();
        end
    endtask : align

    // one or two words back to back, then look at the cycle after the last Q4
    task automatic exec(input logic [15:0] w1, input logic [15:0] w2, input logic two);
        align();
        instr       <= w1;
        instr_valid <= 1'b1;
        repeat (4) @(posedge clk);
        if (two) begin
            instr <= w2;
            repeat (4) @(posedge clk);
        end
        instr_valid <= 1'b0;
        @(negedge clk);
    endtask : exec

    task automatic mv(input logic [6:0] zs, input logic [6:0] zd, input logic we,
                      input logic [11:0] a, input logic [7:0] d);
        exec({9'h1d7, zs}, {9'h1e0, zd}, 1'b1);
        chk_wr(we, a, d);
    endtask : mv

    task automatic do_reset(input logic en);
        @(posedge clk);
        nrst       <= 1'b0;
        ext_enable <= en;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
    endtask : do_reset

    initial begin
        do_reset(1'b1);
        chk(21'(sfp), 21'(SFP_RESET));
        chk(21'(working_reg), 21'(WREG_RESET));
        chk(21'(status_flags), 21'h0_0000);
        exec(16'h6810, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'h010, ALL_ONES);
        exec(16'hfa5a, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'h000, 8'h5a);
        chk(21'(sfp), 21'h0_0fff);
        chk(21'(busy), 21'h0_0000);
        exec(16'he9df, 16'h0000, 1'b0);
        chk(21'(sfp), 21'h0_0fe0);
        chk(21'(pc_load), 21'h0_0001);
        chk(pc_value, rs_top);
        chk(21'(busy), 21'h0_0001);
        align();
        @(negedge clk);
        chk(21'(busy), 21'h0_0000);
        chk(21'(pc_load), 21'h0_0000);
        $display("test push and return done");
        // pointer now 0FE0, so offsets reach both wrap-around and special registers
        i_xsd_mem_model.mem[12'h030] = 8'ha5;
        mv(7'h50, 7'h7f, 1'b1, 12'h05f, 8'ha5);
        mv(7'h03, 7'h40, 1'b1, 12'h020, IND_ZERO);
        for (int i = 0; i < 5; i++) begin
            mv(7'h50, bad_dst[i], 1'b0, 12'h000, 8'h00);
        end
        $display("test indexed move done");
        i_xsd_mem_model.mem[12'h031] = 8'h17;
        i_xsd_mem_model.mem[12'h032] = 8'hf0;
        i_xsd_mem_model.mem[12'h033] = 8'h69;
        i_xsd_mem_model.mem[12'h034] = 8'h80;
        exec(16'h2451, 16'h0000, 1'b0);
        chk(21'(working_reg), 21'h0_0017);
        chk(21'(status_flags), 21'h0_0000);
        exec(16'h2652, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'h032, 8'h07);
        chk(21'(status_flags), 21'h0_0001);
        exec(16'h2453, 16'h0000, 1'b0);
        chk(21'(working_reg), 21'h0_0080);
        chk(21'(status_flags), 21'h0_001a);
        exec(16'h2654, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'h034, 8'h00);
        chk(21'(status_flags), 21'h0_000d);
        exec(16'h8c50, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'h030, 8'he5);
        chk(21'(status_flags), 21'h0_000d);
        exec(16'h6860, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'hf60, ALL_ONES);
        exec(16'hf123, 16'h0000, 1'b0);
        chk_wr(1'b0, 12'h000, 8'h00);
        chk(21'(pc_load), 21'h0_0000);
        chk(21'(sfp), 21'h0_0fe0);
        $display("test indexed offset done");
        do_reset(1'b0);
        exec(16'hfa5a, 16'h0000, 1'b0);
        chk_wr(1'b0, 12'h000, 8'h00);
        chk(21'(sfp), 21'h0_0000);
        exec(16'h6910, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'h510, ALL_ONES);
        exec(16'h6880, 16'h0000, 1'b0);
        chk_wr(1'b1, 12'hf80, ALL_ONES);
        $display("test disabled set done");
        results();
    end
endmodule : tb_xsd_decode
